// *** rtl/smao_pkg.sv ***
// Purpose: Shared constants, types and tables for the audio output stage
// Assumes: 8-bit register address, 16-bit register data
// Notes: Weight and volume tables are pure functions of the ratio code
package smao_pkg;

  localparam int SMAO_AW = 8;
  localparam int SMAO_DW = 16;

  // Register offsets
  localparam logic [7:0] SMAO_OFS_CTRL = 8'h00;
  localparam logic [7:0] SMAO_OFS_SPEECH1 = 8'h01;
  localparam logic [7:0] SMAO_OFS_MEL1 = 8'h05;
  localparam logic [7:0] SMAO_OFS_MEL2 = 8'h06;
  localparam logic [7:0] SMAO_OFS_RELOAD1 = 8'h08;
  localparam logic [7:0] SMAO_OFS_TMR_EN = 8'h0c;
  localparam logic [7:0] SMAO_OFS_OVF = 8'h0d;
  localparam logic [7:0] SMAO_OFS_STATUS = 8'h0e;

  // Reset values
  localparam logic [8:0] SMAO_CTRL_RST = 9'h000;
  localparam logic [7:0] SMAO_SAMPLE_RST = 8'h00;
  localparam logic [7:0] SMAO_RELOAD_RST = 8'h00;
  localparam logic [3:0] SMAO_TMR_EN_RST = 4'h0;

  // Duty is the weighted, scaled mix shifted down by this amount
  localparam int SMAO_DUTY_SHIFT = 9;

  typedef struct packed {
    logic dac2_transparent;
    logic dac1_transparent;
    logic melody_two_enable;
    logic melody_one_enable;
    logic path_dac;
    logic [3:0] pwm_ratio_code;
  } smao_ctrl_t;

  // Channel weights, zero marks an unavailable channel
  typedef struct packed {
    logic [4:0] m1;
    logic [4:0] m2;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] s4;
  } smao_weights_t;

  function automatic smao_weights_t smao_weights(input logic [3:0] code);
    smao_weights_t w;
    w = '0;
    unique case (code)
      4'h0: w = '{5'd1, 5'd1, 5'd4, 5'd4, 5'd4, 5'd0};
      4'h1: w = '{5'd1, 5'd1, 5'd4, 5'd4, 5'd2, 5'd2};
      4'h2: w = '{5'd6, 5'd2, 5'd0, 5'd0, 5'd0, 5'd0};
      4'h3: w = '{5'd4, 5'd4, 5'd0, 5'd0, 5'd0, 5'd0};
      4'h4: w = '{5'd0, 5'd0, 5'd6, 5'd6, 5'd4, 5'd0};
      4'h5: w = '{5'd2, 5'd2, 5'd8, 5'd0, 5'd0, 5'd0};
      4'h6: w = '{5'd2, 5'd2, 5'd4, 5'd4, 5'd0, 5'd0};
      4'h7: w = '{5'd2, 5'd1, 5'd10, 5'd0, 5'd0, 5'd0};
      4'h8: w = '{5'd2, 5'd1, 5'd6, 5'd4, 5'd0, 5'd0};
      4'h9: w = '{5'd1, 5'd1, 5'd12, 5'd0, 5'd0, 5'd0};
      4'ha: w = '{5'd0, 5'd0, 5'd4, 5'd4, 5'd4, 5'd4};
      4'hb: w = '{5'd1, 5'd1, 5'd6, 5'd6, 5'd0, 5'd0};
      4'hc: w = '{5'd0, 5'd0, 5'd8, 5'd8, 5'd0, 5'd0};
      4'hd: w = '{5'd0, 5'd0, 5'd14, 5'd2, 5'd0, 5'd0};
      4'he: w = '{5'd0, 5'd0, 5'd12, 5'd2, 5'd2, 5'd0};
      4'hf: w = '{5'd0, 5'd0, 5'd16, 5'd0, 5'd0, 5'd0};
    endcase
    return w;
  endfunction : smao_weights

  // Volume numerator over 28
  function automatic logic [4:0] smao_vol_num(input logic [3:0] code);
    logic [4:0] n;
    n = '0;
    unique case (code)
      4'hf, 4'he: n = 5'd0;
      4'hd: n = 5'd1;
      4'hb: n = 5'd2;
      4'h9: n = 5'd3;
      4'h7: n = 5'd4;
      4'h5: n = 5'd5;
      4'h3: n = 5'd6;
      4'h1: n = 5'd7;
      4'hc: n = 5'd4;
      4'ha: n = 5'd8;
      4'h8: n = 5'd12;
      4'h6: n = 5'd16;
      4'h4: n = 5'd20;
      4'h2: n = 5'd24;
      4'h0: n = 5'd28;
    endcase
    return n;
  endfunction : smao_vol_num

endpackage : smao_pkg

// *** rtl/smao_speech_timer.sv ***
// Purpose: 8-bit up-count speech timer with auto-reload
// Assumes: Reload value preset by software
// Notes: Overflow is a one-cycle pulse
`timescale 1ns/10ps
module smao_speech_timer
  import smao_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [7:0] speech_timer_reload_value,
  output logic overflow
);

  logic [7:0] count_reg;
  logic ovf_reg;
  wire logic wrap = enable && (count_reg == 8'hff);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= SMAO_RELOAD_RST;
      ovf_reg <= 1'b0;
    end else if (ce) begin
      ovf_reg <= wrap;
      if (wrap) begin
        count_reg <= speech_timer_reload_value;
      end else if (enable) begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end

  assign overflow = ovf_reg && ce;

  sequence s_wrap;
    ce && wrap;
  endsequence

  AST_TMR_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    s_wrap |=> (count_reg == $past(speech_timer_reload_value)) && ovf_reg)
    else $error("speech timer did not reload on wrap");

endmodule : smao_speech_timer

// *** rtl/smao_dac_latch.sv ***
// Purpose: Two-layer DAC sample latch
// Assumes: CPU writes the first layer
// Notes: Second layer moves on timer overflow or follows writes
`timescale 1ns/10ps
module smao_dac_latch
  import smao_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic transparent,
  input wire logic advance,
  output logic [7:0] dac_code
);

  logic [7:0] first_reg;
  logic [7:0] second_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_reg <= SMAO_SAMPLE_RST;
      second_reg <= SMAO_SAMPLE_RST;
    end else if (ce) begin
      if (wr) begin
        first_reg <= wdata;
      end
      if (transparent && wr) begin
        second_reg <= wdata;
      end else if (transparent || advance) begin
        second_reg <= first_reg;
      end
    end
  end

  assign dac_code = second_reg;

  AST_DAC_TRANSPARENT: assert property (@(posedge ref_clk) disable iff (rst)
    ce && transparent && wr |=> dac_code == $past(wdata))
    else $error("transparent latch did not pass write");

  AST_DAC_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !transparent && !advance |=> $stable(dac_code))
    else $error("second latch moved without overflow");

endmodule : smao_dac_latch

// *** rtl/smao_audio_out.sv ***
// Purpose: Speech/melody audio output stage with PWM and DAC paths
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: PWM and DAC outputs rest low while their path is not selected
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps

module smao_audio_out
  import smao_pkg::*;
#(
  parameter int NUM_SPEECH = 4
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [SMAO_AW-1:0] reg_addr,
  input wire logic [SMAO_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [SMAO_DW-1:0] reg_rdata,
  output logic audio_out_one,
  output logic audio_out_two,
  output logic [8:0] audio_pad_one,
  output logic [8:0] audio_pad_two
);

  smao_ctrl_t ctrl_reg;
  logic [7:0] speech_reg [NUM_SPEECH];
  logic [7:0] mel1_reg;
  logic [7:0] mel2_reg;
  logic [7:0] reload_reg [NUM_SPEECH];
  logic [NUM_SPEECH-1:0] tmr_en_reg;
  logic [NUM_SPEECH-1:0] speech_timer_overflow_flag;
  logic [NUM_SPEECH-1:0] ovf_pulse;
  logic [NUM_SPEECH-1:0] speech_wr;
  logic [NUM_SPEECH-1:0] reload_wr;
  logic [SMAO_DW-1:0] rdata_reg;
  logic [SMAO_DW-1:0] rdata_next;
  logic [7:0] pwm_cnt_reg;
  logic pwm_one_reg;
  logic pwm_two_reg;
  logic [8:0] pad_one_reg;
  logic [8:0] pad_two_reg;
  logic [7:0] dac_code_one;
  logic [7:0] dac_code_two;

  // Register decode
  wire logic ctrl_wr = reg_wr && (reg_addr == SMAO_OFS_CTRL);
  wire logic mel1_wr = reg_wr && (reg_addr == SMAO_OFS_MEL1);
  wire logic mel2_wr = reg_wr && (reg_addr == SMAO_OFS_MEL2);
  wire logic tmr_en_wr = reg_wr && (reg_addr == SMAO_OFS_TMR_EN);
  wire logic ovf_clr_wr = reg_wr && (reg_addr == SMAO_OFS_OVF);

  // Mode decode
  wire logic [3:0] pwm_ratio_code = ctrl_reg.pwm_ratio_code;
  wire logic path_dac = ctrl_reg.path_dac;
  wire logic melody_one_enable = ctrl_reg.melody_one_enable;
  wire logic melody_two_enable = ctrl_reg.melody_two_enable;
  wire logic silent = (pwm_ratio_code == 4'hf) || (pwm_ratio_code == 4'he);
  wire smao_weights_t wts = smao_weights(pwm_ratio_code);
  wire logic [4:0] vol_num = smao_vol_num(pwm_ratio_code);

  // Melody gating
  wire logic [7:0] mel1_eff = melody_one_enable ? mel1_reg : 8'h00;
  wire logic [7:0] mel2_eff = melody_two_enable ? mel2_reg : 8'h00;

  // Weighted mixes, one per output
  // Operands widened first so the products keep their upper bits
  wire logic [12:0] mix_one = 13'(wts.m1) * 13'(mel1_eff)
                            + 13'(wts.s1) * 13'(speech_reg[0])
                            + 13'(wts.s3) * 13'(speech_reg[2]);
  wire logic [12:0] mix_two = 13'(wts.m2) * 13'(mel2_eff)
                            + 13'(wts.s2) * 13'(speech_reg[1])
                            + 13'(wts.s4) * 13'(speech_reg[3]);
  wire logic [17:0] scaled_one = 18'(mix_one) * 18'(vol_num);
  wire logic [17:0] scaled_two = 18'(mix_two) * 18'(vol_num);
  wire logic [7:0] duty_one = scaled_one[SMAO_DUTY_SHIFT +: 8];
  wire logic [7:0] duty_two = scaled_two[SMAO_DUTY_SHIFT +: 8];

  // DAC sums
  wire logic [8:0] dac_sum_one = {1'b0, dac_code_one} + {1'b0, mel1_eff};
  wire logic [8:0] dac_sum_two = {1'b0, dac_code_two} + {1'b0, mel2_eff};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SPEECH; gi++) begin : g_ch
      assign speech_wr[gi] = reg_wr && (reg_addr == SMAO_OFS_SPEECH1 + 8'(gi));
      assign reload_wr[gi] = reg_wr && (reg_addr == SMAO_OFS_RELOAD1 + 8'(gi));

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          speech_reg[gi] <= SMAO_SAMPLE_RST;
          reload_reg[gi] <= SMAO_RELOAD_RST;
          speech_timer_overflow_flag[gi] <= 1'b0;
        end else if (ce) begin
          if (speech_wr[gi]) begin
            speech_reg[gi] <= reg_wdata[7:0];
          end
          if (reload_wr[gi]) begin
            reload_reg[gi] <= reg_wdata[7:0];
          end
          // Set beats write-one-to-clear
          if (ovf_pulse[gi]) begin
            speech_timer_overflow_flag[gi] <= 1'b1;
          end else if (ovf_clr_wr && reg_wdata[gi]) begin
            speech_timer_overflow_flag[gi] <= 1'b0;
          end
        end
      end

      smao_speech_timer u_tmr (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .enable(tmr_en_reg[gi]),
        .speech_timer_reload_value(reload_reg[gi]),
        .overflow(ovf_pulse[gi])
      );
    end
  endgenerate

  // DAC latches fed from speech 1 and 2 writes
  smao_dac_latch u_dac_one (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .wr(speech_wr[0]),
    .wdata(reg_wdata[7:0]),
    .transparent(ctrl_reg.dac1_transparent),
    .advance(ovf_pulse[0]),
    .dac_code(dac_code_one)
  );

  smao_dac_latch u_dac_two (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .wr(speech_wr[1]),
    .wdata(reg_wdata[7:0]),
    .transparent(ctrl_reg.dac2_transparent),
    .advance(ovf_pulse[1]),
    .dac_code(dac_code_two)
  );

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= SMAO_CTRL_RST;
      mel1_reg <= SMAO_SAMPLE_RST;
      mel2_reg <= SMAO_SAMPLE_RST;
      tmr_en_reg <= SMAO_TMR_EN_RST;
    end else if (ce) begin
      if (ctrl_wr) begin
        ctrl_reg <= smao_ctrl_t'(reg_wdata[8:0]);
      end
      if (mel1_wr) begin
        mel1_reg <= reg_wdata[7:0];
      end
      if (mel2_wr) begin
        mel2_reg <= reg_wdata[7:0];
      end
      if (tmr_en_wr) begin
        tmr_en_reg <= reg_wdata[NUM_SPEECH-1:0];
      end
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rdata_next = '0;
    if (reg_addr == SMAO_OFS_CTRL) begin
      rdata_next = SMAO_DW'(ctrl_reg);
    end else if (reg_addr == SMAO_OFS_MEL1) begin
      rdata_next = SMAO_DW'(mel1_reg);
    end else if (reg_addr == SMAO_OFS_MEL2) begin
      rdata_next = SMAO_DW'(mel2_reg);
    end else if (reg_addr == SMAO_OFS_TMR_EN) begin
      rdata_next = SMAO_DW'(tmr_en_reg);
    end else if (reg_addr == SMAO_OFS_OVF) begin
      rdata_next = SMAO_DW'(speech_timer_overflow_flag);
    end else if (reg_addr == SMAO_OFS_STATUS) begin
      rdata_next = {dac_code_two, dac_code_one};
    end else begin
      for (int i = 0; i < NUM_SPEECH; i++) begin
        if (reg_addr == SMAO_OFS_SPEECH1 + 8'(i)) begin
          rdata_next = SMAO_DW'(speech_reg[i]);
        end
        if (reg_addr == SMAO_OFS_RELOAD1 + 8'(i)) begin
          rdata_next = SMAO_DW'(reload_reg[i]);
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= reg_rd ? rdata_next : '0;
    end
  end

  assign reg_rdata = rdata_reg;

  // PWM generation
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwm_cnt_reg <= 8'h00;
      pwm_one_reg <= 1'b0;
      pwm_two_reg <= 1'b0;
    end else if (ce) begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      pwm_one_reg <= !path_dac && !silent && (pwm_cnt_reg < duty_one);
      pwm_two_reg <= !path_dac && !silent && (pwm_cnt_reg < duty_two);
    end
  end

  // DAC outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pad_one_reg <= 9'h000;
      pad_two_reg <= 9'h000;
    end else if (ce) begin
      pad_one_reg <= path_dac ? dac_sum_one : 9'h000;
      pad_two_reg <= path_dac ? dac_sum_two : 9'h000;
    end
  end

  assign audio_out_one = pwm_one_reg;
  assign audio_out_two = pwm_two_reg;
  assign audio_pad_one = pad_one_reg;
  assign audio_pad_two = pad_two_reg;

  sequence s_silent_held;
    ce && silent;
  endsequence

  AST_SILENT_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    s_silent_held |=> !audio_out_one && !audio_out_two)
    else $error("PWM toggled while silent");

  AST_DAC_PATH_NO_PWM: assert property (@(posedge ref_clk) disable iff (rst)
    ce && path_dac |=> !audio_out_one && !audio_out_two)
    else $error("PWM active on DAC path");

  AST_DAC_SUM_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    ce && path_dac |=> audio_pad_one == $past(dac_sum_one))
    else $error("first DAC output not speech1 plus melody1");

  AST_DAC_SUM_TWO: assert property (@(posedge ref_clk) disable iff (rst)
    ce && path_dac |=> audio_pad_two == $past(dac_sum_two))
    else $error("second DAC output not speech2 plus melody2");

  AST_PWM_NO_DAC: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !path_dac |=> audio_pad_two == 9'h000)
    else $error("DAC output active on PWM path");

  AST_VOL_ODD: assert property (@(posedge ref_clk) disable iff (rst)
    pwm_ratio_code == 4'hd |-> vol_num == 5'd1)
    else $error("code 1101 not 1/28");

  AST_VOL_EVEN: assert property (@(posedge ref_clk) disable iff (rst)
    pwm_ratio_code == 4'hc |-> vol_num == 5'd4)
    else $error("code 1100 not 1/7");

  AST_VOL_FULL: assert property (@(posedge ref_clk) disable iff (rst)
    pwm_ratio_code == 4'h0 |-> vol_num == 5'd28 && !silent)
    else $error("code 0000 not full volume");

  AST_WEIGHTS: assert property (@(posedge ref_clk) disable iff (rst)
    pwm_ratio_code == 4'hf |-> wts.s1 == 5'd16 && wts.m1 == 5'd0 && wts.s2 == 5'd0)
    else $error("code 1111 weights wrong");

  AST_MEL_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    !melody_one_enable |-> mel1_eff == 8'h00)
    else $error("disabled melody one leaks");

  AST_MEL_GATE_TWO: assert property (@(posedge ref_clk) disable iff (rst)
    !melody_two_enable |-> mel2_eff == 8'h00)
    else $error("disabled melody two leaks");

  AST_OVF_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    ce && (|ovf_pulse) |=> (speech_timer_overflow_flag & $past(ovf_pulse)) == $past(ovf_pulse))
    else $error("overflow flag not set");

  AST_CTRL_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    ce && ctrl_wr |=> pwm_ratio_code == $past(reg_wdata[3:0]))
    else $error("ratio code not stored");

endmodule : smao_audio_out

// *** dv/smao_speaker.sv ***
// Purpose: Speaker model on the two audio outputs
// Assumes: Passive load, PWM outputs are plain logic levels
// Notes: Counts high cycles of each PWM output while measure is high
`timescale 1ns/10ps
module smao_speaker
  import smao_pkg::*;
(
  input wire logic ref_clk,
  input wire logic measure,
  input wire logic pwm_one,
  input wire logic pwm_two,
  output logic [8:0] high_one,
  output logic [8:0] high_two
);
  // Cone follows the average drive over one window
  always_ff @(posedge ref_clk) begin
    if (!measure) begin
      high_one <= 9'h000;
      high_two <= 9'h000;
    end else begin
      high_one <= high_one + 9'(pwm_one);
      high_two <= high_two + 9'(pwm_two);
    end
  end
endmodule : smao_speaker

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the audio output stage
// Assumes: Register map and mixing scale as handed over
// Notes: PWM duty is measured over one full 256-cycle period
`timescale 1ns/10ps
module testbench
  import smao_pkg::*;
;
  logic ref_clk;
  logic rst;
  logic ce;
  logic [SMAO_AW-1:0] reg_addr;
  logic [SMAO_DW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [SMAO_DW-1:0] reg_rdata;
  logic audio_out_one;
  logic audio_out_two;
  logic [8:0] audio_pad_one;
  logic [8:0] audio_pad_two;
  logic measure;
  logic [8:0] high_one;
  logic [8:0] high_two;
  int err_total = 0;
  int n_tests = 0;
  // Summed speech weights per output and volume over 28, per ratio code
  int sum_one[16] = '{8, 6, 0, 0, 10, 8, 4, 10, 6, 12, 8, 6, 8, 14, 14, 16};
  int sum_two[16] = '{4, 6, 0, 0, 6, 0, 4, 0, 4, 0, 8, 6, 8, 2, 2, 0};
  int vol[16] = '{28, 7, 24, 6, 20, 5, 16, 4, 12, 3, 8, 2, 4, 1, 0, 0};

  smao_audio_out #(.NUM_SPEECH(4)) i_smao_audio_out (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .audio_out_one(audio_out_one), .audio_out_two(audio_out_two),
    .audio_pad_one(audio_pad_one), .audio_pad_two(audio_pad_two)
  );

  smao_speaker i_smao_speaker (
    .ref_clk(ref_clk), .measure(measure), .pwm_one(audio_out_one),
    .pwm_two(audio_out_two), .high_one(high_one), .high_two(high_two)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_audio(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: audio got %h expected %h", $time, got, exp);
    end
  endtask : chk_audio

  // Let the new setting take hold for 260 cycles, then count any 256 cycles (one full period)
  task automatic measure_pwm;
    repeat (260) @(posedge ref_clk);
    measure <= 1'b1;
    repeat (256) @(posedge ref_clk);
    measure <= 1'b0;
    #1;
  endtask : measure_pwm

  task automatic wait_pad_two(input logic [8:0] v, input int lim);
    int w;
    for (w = 0; w < lim && audio_pad_two !== v; w++)
      @(posedge ref_clk);
    if (audio_pad_two !== v) begin
      err_total++;
      $display("mismatch at %0t: second pad never reached %h", $time, v);
      report_and_stop();
    end
  endtask : wait_pad_two

  initial begin
    logic [15:0] d;
    int k;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    measure = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk_audio(audio_pad_one, 9'h000);
    rd(SMAO_OFS_CTRL, d);
    chk_reg(d, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk_reg(reg_rdata, 16'h0000);
    // Strobes are ignored while the clock enable is low
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(SMAO_OFS_CTRL, 16'h000f);
    ce <= 1'b1;
    rd(SMAO_OFS_CTRL, d);
    chk_reg(d, 16'h0000);
    rd(8'h07, d);
    chk_reg(d, 16'h0000);
    // Every ratio code with all four speech channels at full scale
    for (k = 0; k < 4; k++)
      wr(SMAO_OFS_SPEECH1 + 8'(k), 16'h00ff);
    for (k = 0; k < 16; k++) begin
      wr(SMAO_OFS_CTRL, 16'(k));
      rd(SMAO_OFS_CTRL, d);
      chk_reg(d, 16'(k));
      measure_pwm();
      chk_audio(high_one, 9'((255 * sum_one[k] * vol[k]) >> SMAO_DUTY_SHIFT));
      chk_audio(high_two, 9'((255 * sum_two[k] * vol[k]) >> SMAO_DUTY_SHIFT));
    end
    // Melody only, each enable combination at full volume
    for (k = 0; k < 4; k++)
      wr(SMAO_OFS_SPEECH1 + 8'(k), 16'h0000);
    wr(SMAO_OFS_MEL1, 16'h00ff);
    wr(SMAO_OFS_MEL2, 16'h00ff);
    for (k = 0; k < 4; k++) begin
      wr(SMAO_OFS_CTRL, 16'(k << 5));
      measure_pwm();
      chk_audio(high_one, (k % 2 == 1) ? 9'd13 : 9'd0);
      chk_audio(high_two, (k / 2 == 1) ? 9'd13 : 9'd0);
    end
    // DAC path: DAC1 transparent with melody one, DAC2 on timer two
    wr(SMAO_OFS_MEL2, 16'h0000);
    wr(SMAO_OFS_SPEECH1 + 8'h01, 16'h0033);
    wr(SMAO_OFS_CTRL, 16'h00b0);
    wr(SMAO_OFS_SPEECH1, 16'h005a);
    repeat (3) @(posedge ref_clk);
    #1;
    chk_audio(audio_pad_one, 9'h159);
    chk_audio(audio_pad_two, 9'h000);
    measure_pwm();
    chk_audio(high_one, 9'h000);
    chk_audio(high_two, 9'h000);
    wr(SMAO_OFS_STATUS, 16'hffff);
    rd(SMAO_OFS_STATUS, d);
    chk_reg(d, 16'h005a);
    wr(SMAO_OFS_RELOAD1 + 8'h01, 16'h00f0);
    wr(SMAO_OFS_TMR_EN, 16'h0002);
    wait_pad_two(9'h033, 300);
    wr(SMAO_OFS_SPEECH1 + 8'h01, 16'h0044);
    wait_pad_two(9'h044, 20);
    rd(SMAO_OFS_STATUS, d);
    chk_reg(d, 16'h445a);
    wr(SMAO_OFS_TMR_EN, 16'h0000);
    rd(SMAO_OFS_OVF, d);
    chk_reg(d, 16'h0002);
    wr(SMAO_OFS_OVF, 16'h0002);
    rd(SMAO_OFS_OVF, d);
    chk_reg(d, 16'h0000);
    // Second DAC in transparent mode follows the write
    wr(SMAO_OFS_CTRL, 16'h0110);
    wr(SMAO_OFS_SPEECH1 + 8'h01, 16'h0021);
    wait_pad_two(9'h021, 4);
    report_and_stop();
  end
endmodule : testbench
